// ===== common/fwsr_pkg.sv
// package for the flash write status polling controller: register map, pin bundle, timing
package fwsr_pkg;
  localparam int unsigned ADDR_W      = 19;
  localparam int unsigned DQ_W        = 8;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_ADDR    = 8'h04;
  localparam logic [7:0]  OFF_STATUS  = 8'h08;
  localparam logic [7:0]  OFF_DATA    = 8'h0C;
  // ctrl bits, write one to act
  localparam int unsigned CTRL_POLL   = 0;
  localparam int unsigned CTRL_RESET  = 1;
  localparam int unsigned CTRL_SINGLE = 2;
  localparam int unsigned CTRL_ABORT  = 3;
  // status bits
  localparam int unsigned ST_BUSY     = 0;
  localparam int unsigned ST_DONE     = 1;
  localparam int unsigned ST_FAIL     = 2;
  localparam int unsigned ST_LIMIT    = 3;
  localparam int unsigned ST_WINDOW   = 4;
  localparam int unsigned ST_TB2      = 5;
  localparam int unsigned ST_RDY      = 6;
  localparam int unsigned ST_ABORTED  = 7;
  // data line positions of the status byte
  localparam int unsigned DQ_TB1      = 6;
  localparam int unsigned DQ_LIMIT    = 5;
  localparam int unsigned DQ_WINDOW   = 3;
  localparam int unsigned DQ_TB2      = 2;
  localparam logic [7:0]  CMD_RESET   = 8'hF0;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
  // flash strobe width and recovery, in ns and in 200 MHz cycles
  localparam int unsigned CLK_NS      = 5;
  localparam int unsigned STROBE_NS   = 70;
  localparam int unsigned RECOVER_NS  = 30;
  localparam logic [7:0]  STROBE_CYC  = 8'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  RECOVER_CYC = 8'((RECOVER_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  CNT_ONE     = 8'h01;
  localparam logic [7:0]  CNT_ZERO    = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DQ_W-1:0]   dq;
    logic [DQ_W-1:0]   dq_oe;
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
  } fwsr_pins_t;

  localparam fwsr_pins_t PINS_IDLE = '{addr: '0, dq: '0, dq_oe: '0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
endpackage

// ===== logic/fwsr_bus_cycle.sv
// one asynchronous flash bus cycle (read or write) with fixed strobe and recovery time
`timescale 1ns/1ps
`default_nettype none
module fwsr_bus_cycle (
  input  wire logic                          clk_in,    // 200 MHz clock
  input  wire logic                          rst_n_in,  // async reset, active low
  input  wire logic                          en_in,     // clock enable
  input  wire logic                          req_in,    // level: run a cycle when idle
  input  wire logic                          write_in,  // 1 write, 0 read
  input  wire logic [fwsr_pkg::ADDR_W-1:0]   addr_in,   // flash address
  input  wire logic [fwsr_pkg::DQ_W-1:0]     wdata_in,  // write byte
  input  wire logic [fwsr_pkg::DQ_W-1:0]     dq_in,     // data lines from flash
  output var fwsr_pkg::fwsr_pins_t           pins_out,  // registered pin drive
  output logic [fwsr_pkg::DQ_W-1:0]          rdata_out, // byte sampled at strobe end
  output logic                               done_out   // one-cycle pulse per cycle
);
  typedef enum logic [2:0] {
    C_IDLE   = 3'b001,
    C_STROBE = 3'b010,
    C_RECOV  = 3'b100
  } fwsr_cyc_t;

  fwsr_cyc_t  state;
  logic [7:0] cnt;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state     <= C_IDLE;
      cnt       <= fwsr_pkg::CNT_ZERO;
      pins_out  <= fwsr_pkg::PINS_IDLE;
      rdata_out <= '0;
      done_out  <= 1'b0;
    end else if (en_in) begin
      done_out <= 1'b0;
      case (state)
        C_IDLE: begin
          if (req_in) begin
            pins_out.addr  <= addr_in;
            pins_out.dq    <= wdata_in;
            pins_out.dq_oe <= {fwsr_pkg::DQ_W{write_in}};
            pins_out.ce_n  <= 1'b0;
            pins_out.oe_n  <= write_in;
            pins_out.we_n  <= ~write_in;
            cnt            <= fwsr_pkg::STROBE_CYC;
            state          <= C_STROBE;
          end
        end
        C_STROBE: begin
          if (cnt == fwsr_pkg::CNT_ONE) begin
            // sample before the strobe rises; data is only held while oe is low
            rdata_out      <= dq_in;
            pins_out.ce_n  <= 1'b1;
            pins_out.oe_n  <= 1'b1;
            pins_out.we_n  <= 1'b1;
            pins_out.dq_oe <= '0;
            done_out       <= 1'b1;
            cnt            <= fwsr_pkg::RECOVER_CYC;
            state          <= C_RECOV;
          end else begin
            cnt <= cnt - fwsr_pkg::CNT_ONE;
          end
        end
        C_RECOV: begin
          if (cnt == fwsr_pkg::CNT_ONE) begin
            state <= C_IDLE;
          end else begin
            cnt <= cnt - fwsr_pkg::CNT_ONE;
          end
        end
        default: state <= C_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== logic/fwsr_host.sv
// flash write status polling controller with an apb register slave
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module fwsr_host (
  input  wire logic                        clk_in,           // 200 MHz clock
  input  wire logic                        rst_n_in,         // async reset, active low
  input  wire logic                        en_in,            // clock enable, freezes all state
  input  wire logic                        psel,             // apb select
  input  wire logic                        penable,          // apb enable
  input  wire logic                        pwrite,           // apb direction
  input  wire logic [7:0]                  paddr,            // apb byte address
  input  wire logic [31:0]                 pwdata,           // apb write data
  output logic [31:0]                      prdata,           // apb read data
  output logic                             pready,           // apb ready
  output logic                             pslverr,          // apb error on unmapped address
  output logic [fwsr_pkg::ADDR_W-1:0]      flash_addr_out,   // flash address
  input  wire logic [fwsr_pkg::DQ_W-1:0]   flash_dq_in,      // flash data lines in
  output logic [fwsr_pkg::DQ_W-1:0]        flash_dq_out,     // flash data lines out
  output logic [fwsr_pkg::DQ_W-1:0]        flash_dq_oe_out,  // data drive enable, high drives
  output logic                             flash_ce_n_out,   // chip select, active low
  output logic                             flash_oe_n_out,   // output enable, active low
  output logic                             flash_we_n_out,   // write strobe, active low
  input  wire logic                        ready_busy_n_in   // flash ready, low while busy
);
  typedef enum logic [7:0] {
    S_IDLE   = 8'b0000_0001,
    S_RD1    = 8'b0000_0010,
    S_RD2    = 8'b0000_0100,
    S_RECHK1 = 8'b0000_1000,
    S_RECHK2 = 8'b0001_0000,
    S_ARRAY  = 8'b0010_0000,
    S_RSTCMD = 8'b0100_0000,
    S_SINGLE = 8'b1000_0000
  } fwsr_state_t;

  fwsr_state_t                  state;
  fwsr_pkg::fwsr_pins_t         pins;
  logic [fwsr_pkg::ADDR_W-1:0]  status_addr;
  logic [fwsr_pkg::DQ_W-1:0]    first_byte;
  logic [fwsr_pkg::DQ_W-1:0]    last_byte;
  logic [fwsr_pkg::DQ_W-1:0]    rdata;
  logic                         cyc_done;
  logic                         cyc_req;
  logic                         cyc_write;
  logic                         st_done;
  logic                         st_fail;
  logic                         st_limit;
  logic                         st_window;
  logic                         st_tb2;
  logic                         st_rdy;
  logic                         st_aborted;
  logic                         abort_pend;
  logic                         apb_wr;
  logic                         tb1_same;
  logic [31:0]                  status_word;

  assign apb_wr      = psel && penable && pready && pwrite;
  assign tb1_same    = first_byte[fwsr_pkg::DQ_TB1] == rdata[fwsr_pkg::DQ_TB1];
  assign cyc_req     = state != S_IDLE;
  assign cyc_write   = state == S_RSTCMD;
  assign status_word = {24'h00_0000, st_aborted, st_rdy, st_tb2, st_window,
                        st_limit, st_fail, st_done, state != S_IDLE};

  fwsr_bus_cycle u_cycle (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .en_in     (en_in),
    .req_in    (cyc_req),
    .write_in  (cyc_write),
    .addr_in   (status_addr),
    .wdata_in  (fwsr_pkg::CMD_RESET),
    .dq_in     (flash_dq_in),
    .pins_out  (pins),
    .rdata_out (rdata),
    .done_out  (cyc_done)
  );

  assign flash_addr_out  = pins.addr;
  assign flash_dq_out    = pins.dq;
  assign flash_dq_oe_out = pins.dq_oe;
  assign flash_ce_n_out  = pins.ce_n;
  assign flash_oe_n_out  = pins.oe_n;
  assign flash_we_n_out  = pins.we_n;

  // apb answer: pready rises in the first access cycle, so every transfer has one wait-free access
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= fwsr_pkg::WORD_ZERO;
    end else if (en_in) begin
      pready  <= psel && !penable && !pready;
      pslverr <= 1'b0;
      if (psel && !penable) begin
        prdata <= fwsr_pkg::WORD_ZERO;
        if (paddr == fwsr_pkg::OFF_CTRL) begin
          prdata <= fwsr_pkg::WORD_ZERO;
        end else if (paddr == fwsr_pkg::OFF_ADDR) begin
          prdata <= {13'h0000, status_addr};
        end else if (paddr == fwsr_pkg::OFF_STATUS) begin
          prdata <= status_word;
        end else if (paddr == fwsr_pkg::OFF_DATA) begin
          prdata <= {24'h00_0000, last_byte};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // status address; software must give an address inside the programmed or erase-selected sector
  // valid status address
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_addr <= '0;
    end else if (en_in && apb_wr && paddr == fwsr_pkg::OFF_ADDR && state == S_IDLE) begin
      status_addr <= pwdata[fwsr_pkg::ADDR_W-1:0];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_rdy <= 1'b0;
    end else if (en_in) begin
      st_rdy <= ready_busy_n_in;
    end
  end

  // abort only lands between double reads, so a resumed poll never trusts a stale first byte
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      abort_pend <= 1'b0;
    end else if (en_in) begin
      if (apb_wr && paddr == fwsr_pkg::OFF_CTRL && pwdata[fwsr_pkg::CTRL_ABORT] && state != S_IDLE) begin
        abort_pend <= 1'b1;
      end else if (state == S_IDLE) begin
        abort_pend <= 1'b0;
      end
    end
  end

  // sequencer; commands other than abort written while busy are ignored
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state      <= S_IDLE;
      first_byte <= '0;
      last_byte  <= '0;
      st_done    <= 1'b0;
      st_fail    <= 1'b0;
      st_limit   <= 1'b0;
      st_window  <= 1'b0;
      st_tb2     <= 1'b0;
      st_aborted <= 1'b0;
    end else if (en_in) begin
      case (state)
        S_IDLE: begin
          if (apb_wr && paddr == fwsr_pkg::OFF_CTRL) begin
            if (pwdata[fwsr_pkg::CTRL_RESET]) begin
              st_done <= 1'b0;
              state   <= S_RSTCMD;
            end else if (pwdata[fwsr_pkg::CTRL_POLL]) begin
              st_done    <= 1'b0;
              st_fail    <= 1'b0;
              st_limit   <= 1'b0;
              st_tb2     <= 1'b0;
              st_aborted <= 1'b0;
              state      <= S_RD1;
            end else if (pwdata[fwsr_pkg::CTRL_SINGLE]) begin
              st_done <= 1'b0;
              state   <= S_SINGLE;
            end
          end
        end
        S_RD1: begin
          if (cyc_done) begin
            first_byte <= rdata;
            state      <= S_RD2;
          end
        end
        S_RD2: begin
          if (cyc_done) begin
            last_byte <= rdata;
            st_tb2    <= first_byte[fwsr_pkg::DQ_TB2] != rdata[fwsr_pkg::DQ_TB2];
            if (tb1_same) begin
              state <= S_ARRAY;
            end else if (rdata[fwsr_pkg::DQ_LIMIT]) begin
              st_limit <= 1'b1;
              state    <= S_RECHK1;
            end else if (abort_pend) begin
              st_aborted <= 1'b1;
              st_done    <= 1'b1;
              state      <= S_IDLE;
            end else begin
              state <= S_RD1;
            end
          end
        end
        S_RECHK1: begin
          if (cyc_done) begin
            first_byte <= rdata;
            state      <= S_RECHK2;
          end
        end
        S_RECHK2: begin
          if (cyc_done) begin
            last_byte <= rdata;
            if (tb1_same) begin
              state <= S_ARRAY;
            end else begin
              st_fail <= 1'b1;
              state   <= S_RSTCMD;
            end
          end
        end
        S_ARRAY: begin
          // the read after toggling stops is the first one carrying array data
          if (cyc_done) begin
            last_byte <= rdata;
            st_done   <= 1'b1;
            state     <= S_IDLE;
          end
        end
        S_RSTCMD: begin
          if (cyc_done) begin
            st_done <= 1'b1;
            state   <= S_IDLE;
          end
        end
        S_SINGLE: begin
          if (cyc_done) begin
            last_byte <= rdata;
            st_window <= rdata[fwsr_pkg::DQ_WINDOW];
            st_done   <= 1'b1;
            state     <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== test/fwsr_flash_model.sv
// behavioural flash device answering status reads and the reset command
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model #(
  parameter logic [7:0] ARRAY = 8'h5A
) (
  input  wire logic [18:0] addr_in,          // address from host
  input  wire logic [7:0]  dq_in,            // resolved data lines
  input  wire logic        ce_n_in,          // chip select, active low
  input  wire logic        oe_n_in,          // output enable, active low
  input  wire logic        we_n_in,          // write strobe, active low
  output logic [7:0]       dq_out,           // flash drive of data lines
  output logic             ready_busy_n_out  // low while an operation runs
);
  int          left   = 0;
  int          n_f0   = 0;
  logic [18:0] f0_addr = '0;
  logic        busy = 1'b0, lim = 1'b0, stuck = 1'b0, ers = 1'b0, win = 1'b0;
  logic        tb1 = 1'b0, tb2 = 1'b0;
  logic [7:0]  last = 8'h00;
  wire logic   rd = !ce_n_in && !oe_n_in;
  wire logic [7:0] status = {1'b0, tb1, lim, 1'b0, win, tb2, 2'b00};

  // status valid as soon as the command is given
  // busy for n reads or stuck, limit and window preset
  task automatic begin_op(input int n, input logic l, input logic s, input logic e, input logic w);
    left = n; lim = l; stuck = s; ers = e; win = w; busy = 1'b1;
  endtask
  task automatic end_op();
    busy = 1'b0;
  endtask

  // status byte while busy, array data once idle
  // the address is not decoded: while busy every address reads the status byte
  // released lines show the inverse of the last byte, so a stale sample cannot pass
  assign dq_out = rd ? (busy ? status : ARRAY) : ~last;
  assign ready_busy_n_out = ~busy;

  // each finished read inverts the active toggle bits
  always @(negedge rd) begin
    last = busy ? status : ARRAY;
    if (busy) begin
      tb1 = ~tb1;
      if (ers) tb2 = ~tb2;
      left = left - 1;
      if (left <= 0 && !stuck) busy = 1'b0;
    end
  end

  // reset command returns the device to array reads
  always @(negedge we_n_in) begin
    // data lines and select move in the same step as the strobe; look once they settle
    #1;
    if (!ce_n_in && dq_in == 8'hF0) begin
      n_f0 = n_f0 + 1;
      f0_addr = addr_in;
      // window closed: the erase runs on and the command is ignored
      if (!(busy && ers && win)) busy = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== test/fwsr_host_asserts.sv
// concurrent checks on the apb slave and the flash strobe timing
`timescale 1ns/1ps
`default_nettype none
module fwsr_host_asserts (
  input wire logic                      clk_in,          // clock
  input wire logic                      rst_n_in,        // reset, active low
  input wire logic                      psel,            // apb select
  input wire logic                      penable,         // apb enable
  input wire logic [31:0]               prdata,          // apb read data
  input wire logic                      pready,          // apb ready
  input wire logic                      pslverr,         // apb error
  input wire logic [fwsr_pkg::ADDR_W-1:0] flash_addr_out, // flash address
  input wire logic [fwsr_pkg::DQ_W-1:0] flash_dq_out,    // flash data out
  input wire logic [fwsr_pkg::DQ_W-1:0] flash_dq_oe_out, // flash data enable
  input wire logic                      flash_ce_n_out,  // chip select
  input wire logic                      flash_oe_n_out,  // output enable
  input wire logic                      flash_we_n_out   // write strobe
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_READY_AFTER_SETUP: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_SLVERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("pslverr without pready or with data");
  AST_STROBE_WIDTH: assert property ($fell(flash_ce_n_out) |->
    !flash_ce_n_out [*8] ##1 !flash_ce_n_out [*6] ##1 flash_ce_n_out)
    else $error("strobe not 14 cycles");
  AST_RECOVERY: assert property ($rose(flash_ce_n_out) |-> flash_ce_n_out [*6])
    else $error("recovery shorter than 6 cycles");
  AST_WRITE_RESET_CMD: assert property (!flash_we_n_out |->
    !flash_ce_n_out && flash_dq_oe_out == 8'hFF && flash_dq_out == fwsr_pkg::CMD_RESET)
    else $error("write strobe without reset byte");
  AST_READ_RELEASED: assert property (!flash_oe_n_out |->
    !flash_ce_n_out && flash_we_n_out && flash_dq_oe_out == 8'h00)
    else $error("read with data lines driven");
  AST_ADDR_STEADY: assert property (!flash_ce_n_out && !$past(flash_ce_n_out) |-> $stable(flash_addr_out))
    else $error("address moved inside a cycle");
endmodule
bind fwsr_host fwsr_host_asserts u_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_addr_out(flash_addr_out), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_out(flash_dq_oe_out), .flash_ce_n_out(flash_ce_n_out), .flash_oe_n_out(flash_oe_n_out),
  .flash_we_n_out(flash_we_n_out));
`default_nettype wire

// ===== test/tb_top.sv
// testbench: apb driven polling controller against the flash model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk_in = 1'b0, rst_n_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
  logic        pready, pslverr, rerr;
  logic [18:0] faddr;
  logic [7:0]  hdq, hoe, mdq, fdq;
  logic        ce_n, oe_n, we_n, rb_n;
  int          errors = 0, n_compared = 0, cyc = 0;

  always #2.5 clk_in = ~clk_in;
  // whoever enables its drivers owns the data lines
  assign fdq = (hoe != 8'h00) ? hdq : mdq;

  fwsr_host u_fwsr_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .en_in(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr_out(faddr), .flash_dq_in(fdq), .flash_dq_out(hdq), .flash_dq_oe_out(hoe), .flash_ce_n_out(ce_n),
    .flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .ready_busy_n_in(rb_n));
  fwsr_flash_model u_fwsr_flash_model (.addr_in(faddr), .dq_in(fdq), .ce_n_in(ce_n), .oe_n_in(oe_n),
    .we_n_in(we_n), .dq_out(mdq), .ready_busy_n_out(rb_n));

  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      $display("[FAIL] %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    n_compared++;
    if ((got & mask) !== (exp & mask)) begin
      errors++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input int b);
    apb(1'b1, fwsr_pkg::OFF_CTRL, 32'h0000_0001 << b);
  endtask

  // the controller runs the whole exchange; status is read until done
  task automatic wait_done();
    do apb(1'b0, fwsr_pkg::OFF_STATUS, 32'h0000_0000); while (rdat[fwsr_pkg::ST_DONE] !== 1'b1);
  endtask

  initial begin
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, fwsr_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0040, 32'hFFFF_FFFF);
    apb(1'b0, fwsr_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rdat, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({rdat[30:0], rerr}, 32'h0000_0001, 32'hFFFF_FFFF);
    apb(1'b1, fwsr_pkg::OFF_ADDR, 32'h0007_1234);
    apb(1'b0, fwsr_pkg::OFF_ADDR, 32'h0000_0000);
    chk(rdat, 32'h0007_1234, 32'hFFFF_FFFF);
    // toggling stops after four reads, then array data
    u_fwsr_host_flash_start(4, 1'b0, 1'b0, 1'b0, 1'b0);
    chk(rdat, 32'h0000_0042, 32'hFFFF_FFFF);
    apb(1'b0, fwsr_pkg::OFF_DATA, 32'h0000_0000);
    chk(rdat, 32'h0000_005A, 32'h0000_00FF);
    // limit bit set from the start, toggling stops after two reads: still a success
    u_fwsr_host_flash_start(2, 1'b1, 1'b0, 1'b0, 1'b0);
    chk(rdat, 32'h0000_004A, 32'hFFFF_FFFF);
    // stuck toggling with limit bit: failure and one reset write
    u_fwsr_host_flash_start(0, 1'b1, 1'b1, 1'b0, 1'b0);
    chk(rdat, 32'h0000_004E, 32'hFFFF_FFFF);
    chk(32'(u_fwsr_flash_model.n_f0), 32'h0000_0001, 32'hFFFF_FFFF);
    chk(32'(u_fwsr_flash_model.f0_addr), 32'h0007_1234, 32'hFFFF_FFFF);
    // endless erase toggling, stopped by abort
    u_fwsr_flash_model.begin_op(0, 1'b0, 1'b1, 1'b1, 1'b0);
    cmd(fwsr_pkg::CTRL_POLL);
    repeat (100) @(posedge clk_in);
    cmd(fwsr_pkg::CTRL_ABORT);
    wait_done();
    chk(rdat, 32'h0000_00A2, 32'hFFFF_FFFF);
    u_fwsr_flash_model.end_op();
    cmd(fwsr_pkg::CTRL_POLL);
    wait_done();
    chk(rdat, 32'h0000_0042, 32'h0000_0047);
    // single reads of the erase window bit, high then low
    u_fwsr_flash_model.begin_op(0, 1'b0, 1'b1, 1'b1, 1'b1);
    cmd(fwsr_pkg::CTRL_SINGLE);
    wait_done();
    chk(rdat, 32'h0000_0012, 32'h0000_0017);
    cmd(fwsr_pkg::CTRL_RESET);
    wait_done();
    chk(32'(u_fwsr_flash_model.n_f0), 32'h0000_0002, 32'hFFFF_FFFF);
    chk(32'(u_fwsr_flash_model.busy), 32'h0000_0001, 32'h0000_0001);
    u_fwsr_flash_model.begin_op(0, 1'b0, 1'b1, 1'b1, 1'b0);
    cmd(fwsr_pkg::CTRL_SINGLE);
    wait_done();
    chk(rdat, 32'h0000_0002, 32'h0000_0017);
    // reset in mid-poll: status and address registers return to their reset values
    cmd(fwsr_pkg::CTRL_POLL);
    repeat (30) @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    apb(1'b0, fwsr_pkg::OFF_STATUS, 32'h0000_0000);
    chk(rdat, 32'h0000_0000, 32'hFFFF_FFFF);
    apb(1'b0, fwsr_pkg::OFF_ADDR, 32'h0000_0000);
    chk(rdat, 32'h0000_0000, 32'hFFFF_FFFF);
    complete_run();
  end

  task automatic u_fwsr_host_flash_start(input int n, input logic l, input logic s, input logic e, input logic w);
    u_fwsr_flash_model.begin_op(n, l, s, e, w);
    cmd(fwsr_pkg::CTRL_POLL);
    wait_done();
  endtask
endmodule
`default_nettype wire
